// ### rtl/csie_pkg.sv
// Purpose: Constants for the clock select and interrupt enable block.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes:   Printed offsets are not multiples of four, so byte address is four times the index.
package csie_pkg;
   // ****************************************
   // Register map.
   // ****************************************
   localparam logic [3:0] CSIE_IDX_IRQ_ENABLE = 4'h4;
   localparam logic [3:0] CSIE_IDX_SOURCE_SELECT = 4'h5;
   localparam logic [3:0] CSIE_IDX_STATUS = 4'h6;
   localparam logic [3:0] CSIE_IDX_FLAG_CLEAR = 4'h7;
   localparam logic [7:0] CSIE_IRQ_ENABLE_RST = 8'h00;
   localparam logic [7:0] CSIE_SOURCE_SELECT_RST = 8'h00;
   // Clock controls out of reset: oscillator, clocks and timers running, loop source off.
   localparam logic [7:0] CSIE_CTL_RST = 8'hda;
   localparam logic [7:0] CSIE_IRQ_ENABLE_MASK = 8'h92;
   // ****************************************
   // Field positions.
   // ****************************************
   localparam int CSIE_TICK_IE_BIT = 7;
   localparam int CSIE_SETTLE_IE_BIT = 4;
   localparam int CSIE_SELF_IE_BIT = 1;
   localparam int CSIE_SEL_LOOP_BIT = 7;
   localparam int CSIE_SEL_PSEUDO_BIT = 6;
   localparam int CSIE_SEL_SYSWAIT_BIT = 5;
   localparam int CSIE_SEL_ROAWAIT_BIT = 4;
   localparam int CSIE_SEL_LOOPWAIT_BIT = 3;
   localparam int CSIE_SEL_COREWAIT_BIT = 2;
   localparam int CSIE_SEL_TICKWAIT_BIT = 1;
   localparam int CSIE_SEL_DOGWAIT_BIT = 0;
   // Flag positions in the status register, matching the enable bits.
   localparam int CSIE_FLG_TICK_BIT = 7;
   localparam int CSIE_FLG_SETTLE_BIT = 4;
   localparam int CSIE_FLG_SELF_BIT = 1;
   localparam int CSIE_ST_LOCK_BIT = 3;
   localparam int CSIE_ST_TRACK_BIT = 2;
   localparam int CSIE_ST_SCM_BIT = 0;
   // ****************************************
   // Bus answers.
   // ****************************************
   localparam logic [1:0] CSIE_RESP_OKAY = 2'h0;
   localparam logic [1:0] CSIE_RESP_SLVERR = 2'h2;
endpackage

// ### rtl/csie_clock_select.sv
// Purpose: Interrupt enables, system clock source select and low-power clock gating.
// Assumes: All inputs synchronous to ref_clk; flag events are one-cycle pulses.
// Notes:   Registers reached over AXI4-Lite; analogue parts sit outside.
// Operation
// R01: tick flag and enable raise request
// R02: settle flag and enable raise request
// R03: self-clocked flag and enable raise request
// R04: interrupt enable register always read/write
// R05: ignore loop select when loop unstable
// R06: clear loop select on scm, stop, wait
// R07: select drives system clock source, bus/2
// R08: pseudo-halt keeps oscillator in stop
// R09: system clocks stop in wait when set
// R10: reduced amplitude in wait when set
// R11: loop powered down in wait, select cleared
// R12: force automatic bandwidth while loop-wait set
// R13: core clock stops in wait when set
// R14: tick timer stops and resets in wait
// R15: watchdog stops and resets in wait
// R16: watchdog-wait bit write-once in normal modes
// R17: tick flag set per period, write-one clears
// R18: settle flag set on lock change
// R19: self-clocked flag set on mode change
// R20: one combined interrupt request output
`timescale 1ns/1ps
`default_nettype none
module csie_clock_select
   import csie_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // AXI4-Lite write address and data.
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Generator status and events.
   input wire logic tick_period_end,
   input wire logic loop_lock,
   input wire logic loop_track,
   input wire logic self_clocked_mode,
   input wire logic auto_bandwidth,
   input wire logic special_mode,
   input wire logic wait_entry,
   input wire logic wait_active,
   input wire logic stop_entry,
   input wire logic stop_active,
   // Clock control outputs.
   output logic irq,
   output logic system_clock_from_loop,
   output logic oscillator_enable,
   output logic oscillator_reduced_amp,
   output logic system_clocks_run,
   output logic core_clock_run,
   output logic loop_power_down,
   output logic auto_bandwidth_force,
   output logic tick_timer_run,
   output logic tick_timer_reset,
   output logic watchdog_run,
   output logic watchdog_reset
);
   // ****************************************
   // Helper functions.
   // ****************************************
   // Register index from a byte address; misaligned low bits are ignored.
   function automatic logic [3:0] csie_index(input logic [5:0] addr);
      csie_index = addr[5:2];
   endfunction
   // Write-one-to-clear with set winning over the clear.
   // An event that lands on the clearing write is therefore never lost.
   function automatic logic csie_flag(input logic cur, input logic set, input logic clr);
      csie_flag = set | (cur & ~clr);
   endfunction

   // ****************************************
   // State declarations.
   // ****************************************
   logic [7:0] irq_enable_r, irq_enable_nxt;
   logic [7:0] source_select_r, source_select_nxt;
   logic [7:0] flags_r, flags_nxt;
   logic lock_prev_r, lock_prev_nxt;
   logic scm_prev_r, scm_prev_nxt;
   logic dog_written_r, dog_written_nxt;
   logic aw_held_r, aw_held_nxt;
   logic [5:0] aw_addr_r, aw_addr_nxt;
   logic w_held_r, w_held_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [7:0] ctl_r, ctl_nxt;
   // Decoded write strobe and the byte it carries; only the lowest lane is used.
   logic do_write;
   logic [3:0] wr_idx;
   logic [7:0] wr_byte;
   logic wr_lane;
   // Loop guard terms shared by the select write and the forced clear.
   logic loop_stable;
   logic loop_select_clear;

   // ****************************************
   // Bus write path.
   // ****************************************
   // Address and data are taken in either order; the write fires when both are held.
   // Both readies stay low until the answer is taken, which keeps one write in flight.
   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready = ~w_held_r & ~bvalid_r;
   assign do_write = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_idx = csie_index(aw_addr_r);
   assign wr_byte = w_data_r[7:0];
   assign wr_lane = w_strb_r[0];
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Next state of the write channel.
   // Unmapped indices still complete, with an error answer, so a master never hangs.
   always_comb begin
      aw_held_nxt = aw_held_r;
      aw_addr_nxt = aw_addr_r;
      w_held_nxt = w_held_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         case (wr_idx)
            CSIE_IDX_IRQ_ENABLE, CSIE_IDX_SOURCE_SELECT, CSIE_IDX_FLAG_CLEAR: begin
               bresp_nxt = CSIE_RESP_OKAY;
            end
            default: begin
               bresp_nxt = CSIE_RESP_SLVERR;
            end
         endcase
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   // ****************************************
   // Control registers and flags.
   // ****************************************
   // Loop is usable when locked under automatic bandwidth, else when tracking.
   // A forced automatic bandwidth counts the same as one set by software.
   assign loop_stable = (auto_bandwidth | auto_bandwidth_force) ? loop_lock : loop_track;
   // Leaving the loop selected into these modes would clock the part from a dead loop.
   assign loop_select_clear = self_clocked_mode | stop_entry
      | (wait_entry & source_select_r[CSIE_SEL_LOOPWAIT_BIT]);   // [R06] [R11]

   // A write of one to the loop select is dropped, not delayed, while the loop is unstable.
   // The forced clear comes after the write so it wins when both fall in one cycle.
   // Register, flag and edge-tracking next values.
   always_comb begin
      irq_enable_nxt = irq_enable_r;
      source_select_nxt = source_select_r;
      dog_written_nxt = dog_written_r;
      lock_prev_nxt = loop_lock;
      scm_prev_nxt = self_clocked_mode;
      flags_nxt = flags_r;
      if (do_write && wr_lane && wr_idx == CSIE_IDX_IRQ_ENABLE) begin
         irq_enable_nxt = wr_byte & CSIE_IRQ_ENABLE_MASK;   // [R04]
      end
      if (do_write && wr_lane && wr_idx == CSIE_IDX_SOURCE_SELECT) begin
         source_select_nxt[6:1] = wr_byte[6:1];   // [R08] [R09] [R10] [R13] [R14]
         if (!wr_byte[CSIE_SEL_LOOP_BIT] || loop_stable) begin
            source_select_nxt[CSIE_SEL_LOOP_BIT] = wr_byte[CSIE_SEL_LOOP_BIT];   // [R05]
         end
         // Only the first write counts outside special modes.
         if (special_mode || !dog_written_r) begin
            source_select_nxt[CSIE_SEL_DOGWAIT_BIT] = wr_byte[CSIE_SEL_DOGWAIT_BIT];   // [R16]
            dog_written_nxt = 1'b1;   // [R16]
         end
      end
      if (loop_select_clear) begin
         source_select_nxt[CSIE_SEL_LOOP_BIT] = 1'b0;   // [R06]
      end
      // Flag lanes outside the three generator events are forced to zero below.
      flags_nxt[CSIE_FLG_TICK_BIT] = csie_flag(flags_r[CSIE_FLG_TICK_BIT], tick_period_end,
         do_write && wr_lane && wr_idx == CSIE_IDX_FLAG_CLEAR
         && wr_byte[CSIE_FLG_TICK_BIT]);   // [R17]
      flags_nxt[CSIE_FLG_SETTLE_BIT] = csie_flag(flags_r[CSIE_FLG_SETTLE_BIT],
         loop_lock != lock_prev_r,
         do_write && wr_lane && wr_idx == CSIE_IDX_FLAG_CLEAR
         && wr_byte[CSIE_FLG_SETTLE_BIT]);   // [R18] [R17]
      flags_nxt[CSIE_FLG_SELF_BIT] = csie_flag(flags_r[CSIE_FLG_SELF_BIT],
         self_clocked_mode != scm_prev_r,
         do_write && wr_lane && wr_idx == CSIE_IDX_FLAG_CLEAR
         && wr_byte[CSIE_FLG_SELF_BIT]);   // [R19] [R17]
      flags_nxt = flags_nxt & CSIE_IRQ_ENABLE_MASK;
   end

   // ****************************************
   // Bus read path.
   // ****************************************
   // Only one read is in flight: a new address waits until the answer has been taken.
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Read data is captured at the address handshake and answered a cycle later.
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = CSIE_RESP_OKAY;
         case (csie_index(s_axi_araddr))
            CSIE_IDX_IRQ_ENABLE: begin
               rdata_nxt = {24'h000000, irq_enable_r};   // [R04]
            end
            CSIE_IDX_SOURCE_SELECT: begin
               rdata_nxt = {24'h000000, source_select_r};
            end
            CSIE_IDX_STATUS: begin
               // Live status levels are merged with the sticky flags at capture time.
               rdata_nxt = {24'h000000, flags_r | {4'h0, loop_lock, loop_track, 1'b0,
                  self_clocked_mode}};
            end
            CSIE_IDX_FLAG_CLEAR: begin
               rdata_nxt = 32'h00000000;
            end
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = CSIE_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // ****************************************
   // Clock control outputs.
   // ****************************************
   // The ctl_r outputs are registered so their gating signals never glitch; the divider resets follow wait_entry directly.
   // Stop overrides the system and core clock wait options; the timers follow only their own wait bits.
   always_comb begin
      ctl_nxt = 8'h00;
      ctl_nxt[0] = source_select_r[CSIE_SEL_LOOP_BIT];   // [R07]
      ctl_nxt[1] = ~stop_active | source_select_r[CSIE_SEL_PSEUDO_BIT];   // [R08]
      ctl_nxt[2] = (stop_active & source_select_r[CSIE_SEL_PSEUDO_BIT])
         | (wait_active & source_select_r[CSIE_SEL_ROAWAIT_BIT]);   // [R08] [R10]
      ctl_nxt[3] = ~stop_active
         & ~(wait_active & source_select_r[CSIE_SEL_SYSWAIT_BIT]);   // [R09]
      ctl_nxt[4] = ~stop_active
         & ~(wait_active & source_select_r[CSIE_SEL_COREWAIT_BIT]);   // [R13]
      ctl_nxt[5] = wait_active & source_select_r[CSIE_SEL_LOOPWAIT_BIT];   // [R11]
      ctl_nxt[6] = ~(wait_active & source_select_r[CSIE_SEL_TICKWAIT_BIT]);   // [R14]
      ctl_nxt[7] = ~(wait_active & source_select_r[CSIE_SEL_DOGWAIT_BIT]);   // [R15]
   end

   assign system_clock_from_loop = ctl_r[0];
   assign oscillator_enable = ctl_r[1];
   assign oscillator_reduced_amp = ctl_r[2];
   assign system_clocks_run = ctl_r[3];
   assign core_clock_run = ctl_r[4];
   assign loop_power_down = ctl_r[5];
   assign tick_timer_run = ctl_r[6];
   assign watchdog_run = ctl_r[7];
   // Force is a direct level so software sees the effect with no lag.
   assign auto_bandwidth_force = source_select_r[CSIE_SEL_LOOPWAIT_BIT];   // [R12]
   // Divider resets pulse in the cycle the part enters wait.
   // Limitation: a wait entry that lands on a select write still uses the old bits.
   assign tick_timer_reset = wait_entry & source_select_r[CSIE_SEL_TICKWAIT_BIT];   // [R14]
   assign watchdog_reset = wait_entry & source_select_r[CSIE_SEL_DOGWAIT_BIT];   // [R15]
   // Request is held as long as any enabled flag stays set.
   // No stretch or edge logic: the request drops as soon as software clears the flag.
   assign irq = |(flags_r & irq_enable_r);   // [R01] [R02] [R03] [R20]

   // ****************************************
   // State registers.
   // ****************************************
   // Synchronous reset; every register returns to its idle value.
   // Limitation: outputs show reset values only from the first edge with reset low.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_enable_r <= CSIE_IRQ_ENABLE_RST;
         source_select_r <= CSIE_SOURCE_SELECT_RST;
         flags_r <= 8'h00;
         lock_prev_r <= 1'b0;
         scm_prev_r <= 1'b0;
         dog_written_r <= 1'b0;
         aw_held_r <= 1'b0;
         aw_addr_r <= 6'h00;
         w_held_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= CSIE_RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= CSIE_RESP_OKAY;
         rdata_r <= 32'h00000000;
         ctl_r <= CSIE_CTL_RST;
      end else begin
         irq_enable_r <= irq_enable_nxt;
         source_select_r <= source_select_nxt;
         flags_r <= flags_nxt;
         lock_prev_r <= lock_prev_nxt;
         scm_prev_r <= scm_prev_nxt;
         dog_written_r <= dog_written_nxt;
         aw_held_r <= aw_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_held_r <= w_held_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         ctl_r <= ctl_nxt;
      end
   end
endmodule
`default_nettype wire

// ### verification/csie_clock_select_asserts.sv
// Purpose: Port assertions for the clock select block.
// Assumes: Registered outputs lag their causes by one or two cycles.
// Notes:   Attached by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module csie_clock_select_asserts (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Mode inputs.
   input wire logic loop_lock,
   input wire logic loop_track,
   input wire logic self_clocked_mode,
   input wire logic wait_entry,
   input wire logic wait_active,
   input wire logic stop_entry,
   input wire logic stop_active,
   // Clock controls.
   input wire logic system_clock_from_loop,
   input wire logic oscillator_enable,
   input wire logic system_clocks_run,
   input wire logic core_clock_run,
   input wire logic loop_power_down,
   input wire logic tick_timer_run,
   input wire logic tick_timer_reset,
   input wire logic watchdog_run,
   input wire logic watchdog_reset
);
   // ****************
   // Properties.
   // ****************
   // Reset masks every check, though $past and $rose can still sample values from before release.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_scm_held; self_clocked_mode [*2]; endsequence
   sequence s_sel_rise; $rose(system_clock_from_loop); endsequence
   property p_scm_clear; s_scm_held |=> !system_clock_from_loop; endproperty
   a_scm_clear: assert property (p_scm_clear) else $error("loop kept in self-clock");
   property p_stop_clear; stop_entry |-> ##[1:2] !system_clock_from_loop; endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("loop kept in stop");
   property p_sel_rise; s_sel_rise |-> $past(loop_lock || loop_track, 2); endproperty
   a_sel_rise: assert property (p_sel_rise) else $error("unstable loop selected");
   property p_osc; !stop_active |=> oscillator_enable; endproperty
   a_osc: assert property (p_osc) else $error("oscillator off outside stop");
   property p_run;
      !wait_active && !stop_active |=> system_clocks_run && core_clock_run;
   endproperty
   a_run: assert property (p_run) else $error("clocks stopped while running");
   property p_timers; !wait_active |=> tick_timer_run && watchdog_run; endproperty
   a_timers: assert property (p_timers) else $error("timer stopped outside wait");
   property p_div_rst; tick_timer_reset || watchdog_reset |-> wait_entry; endproperty
   a_div_rst: assert property (p_div_rst) else $error("divider reset outside wait");
   property p_pdown; loop_power_down |-> $past(wait_active); endproperty
   a_pdown: assert property (p_pdown) else $error("loop down outside wait");
endmodule
bind csie_clock_select csie_clock_select_asserts csie_clock_select_asserts_i (.*);
`default_nettype wire

// ### verification/tb_csie_clock_select.sv
// Purpose: Self-checking bench for the clock select block.
// Assumes: Registered outputs settle within three cycles.
// Notes:   Model state is kept in sel_m, en_m and flg_m.
`timescale 1ns/1ps
`default_nettype none
module tb_csie_clock_select;
   import csie_pkg::*;
   localparam logic [5:0] A_EN = {CSIE_IDX_IRQ_ENABLE, 2'b00};
   localparam logic [5:0] A_SEL = {CSIE_IDX_SOURCE_SELECT, 2'b00};
   localparam logic [5:0] A_ST = {CSIE_IDX_STATUS, 2'b00};
   localparam logic [5:0] A_CLR = {CSIE_IDX_FLAG_CLEAR, 2'b00};
   logic ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic tick_period_end, loop_lock, loop_track, self_clocked_mode, auto_bandwidth, special_mode;
   logic wait_entry, wait_active, stop_entry, stop_active, system_clock_from_loop;
   logic oscillator_enable, oscillator_reduced_amp, system_clocks_run, core_clock_run;
   logic loop_power_down, auto_bandwidth_force, tick_timer_run, tick_timer_reset;
   logic watchdog_run, watchdog_reset;
   logic [31:0] seed = 32'h0939;
   logic [7:0] en_m = 8'h00, sel_m = 8'h00, flg_m = 8'h00;
   logic dog_done = 1'b0;
   int fail_count = 0, check_count = 0, cyc = 0;
   logic [7:0] cfg [2] = '{8'hae, 8'hd2};

   csie_clock_select csie_clock_select_i (.*);

   // Free-running 200 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ****************
   // Helpers.
   // ****************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Address and data are offered together and dropped one by one as taken.
   task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      // Wait for the answer itself; the response is taken at its handshake edge.
      do begin
         @(posedge ref_clk);
         if (!aw_done && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge ref_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [5:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk("rdata", {24'h000000, e}, d);
      chk("rresp", {30'h0, CSIE_RESP_OKAY}, {30'h0, r});
   endtask

   // A loop select of one only sticks while the loop is stable.
   task automatic wsel(input logic [7:0] v);
      logic [1:0] r;
      logic ok;
      wr(A_SEL, v, r);
      // Stability is judged by the levels the design saw while the write was applied.
      ok = (auto_bandwidth | sel_m[3]) ? loop_lock : loop_track;
      if (!dog_done | special_mode) sel_m[0] = v[0];
      dog_done = 1'b1;
      sel_m[6:1] = v[6:1];
      sel_m[7] = v[7] & (sel_m[7] | ok) & ~self_clocked_mode;
      chk("bresp", {30'h0, CSIE_RESP_OKAY}, {30'h0, r});
   endtask

   task automatic cchk(input logic w, input logic st);
      repeat (3) @(negedge ref_clk);
      chk("ctl", {23'h0, ~st | sel_m[6], (st & sel_m[6]) | (w & sel_m[4]),
         ~st & ~(w & sel_m[5]), ~st & ~(w & sel_m[2]), w & sel_m[3], sel_m[3],
         ~(w & sel_m[1]), ~(w & sel_m[0]), sel_m[7]}, {23'h0, oscillator_enable,
         oscillator_reduced_amp, system_clocks_run, core_clock_run, loop_power_down,
         auto_bandwidth_force, tick_timer_run, watchdog_run, system_clock_from_loop});
      // Return on a rising edge so callers drive inputs there.
      @(posedge ref_clk);
   endtask

   // Enter wait or stop, check the controls inside, then leave again.
   task automatic lp(input logic st);
      @(posedge ref_clk);
      {stop_entry, stop_active, wait_entry, wait_active} <= {st, st, ~st, ~st};
      @(negedge ref_clk);
      chk("divrst", {30'h0, ~st & sel_m[1], ~st & sel_m[0]},
         {30'h0, tick_timer_reset, watchdog_reset});
      if (st | sel_m[3]) sel_m[7] = 1'b0;
      @(posedge ref_clk);
      {stop_entry, wait_entry} <= 2'b00;
      cchk(~st, st);
      @(posedge ref_clk);
      {stop_active, wait_active} <= 2'b00;
      cchk(1'b0, 1'b0);
   endtask

   // Bit 0 pulses the tick, bit 1 toggles lock, bit 2 toggles self-clock mode.
   task automatic ev(input logic [2:0] e);
      @(posedge ref_clk);
      tick_period_end <= e[0];
      loop_lock <= loop_lock ^ e[1];
      self_clocked_mode <= self_clocked_mode ^ e[2];
      @(posedge ref_clk);
      tick_period_end <= 1'b0;
      flg_m = flg_m | {e[0], 2'b00, e[1], 2'b00, e[2], 1'b0};
      if (self_clocked_mode) sel_m[7] = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("irq", {31'h0, |(flg_m & en_m)}, {31'h0, irq});
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // A hang is cut short well past the expected run length.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end

   // ****************
   // Scenarios.
   // ****************
   initial begin
      logic [1:0] r;
      logic [31:0] d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rst_n} = '0;
      {tick_period_end, loop_lock, loop_track, self_clocked_mode, special_mode} = '0;
      {wait_entry, wait_active, stop_entry, stop_active} = '0;
      s_axi_wstrb = 4'hf;
      auto_bandwidth = 1'b1;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(A_EN, CSIE_IRQ_ENABLE_RST);
      rchk(A_SEL, CSIE_SOURCE_SELECT_RST);
      cchk(1'b0, 1'b0);
      $display("reset test done");
      wsel(8'h81);
      wsel(8'h00);
      rchk(A_SEL, sel_m);
      loop_track <= 1'b1;
      auto_bandwidth <= 1'b0;
      wsel(8'h80);
      cchk(1'b0, 1'b0);
      loop_track <= 1'b0;
      ev(3'b010);
      wsel(8'h08);
      wsel(8'h88);
      rchk(A_SEL, sel_m);
      cchk(1'b0, 1'b0);
      // Special modes let the watchdog-wait bit change on every write.
      special_mode <= 1'b1;
      wsel(8'h08);
      rchk(A_SEL, sel_m);
      wsel(8'h09);
      special_mode <= 1'b0;
      $display("select test done");
      auto_bandwidth <= 1'b1;
      foreach (cfg[i]) begin
         wsel(cfg[i]);
         lp(1'b0);
         wsel(cfg[i]);
         lp(1'b1);
      end
      $display("low power test done");
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(A_EN, seed[7:0], r);
         en_m = seed[7:0] & CSIE_IRQ_ENABLE_MASK;
         rchk(A_EN, en_m);
         ev(seed[10:8]);
         rchk(A_ST, {flg_m[7], 2'b00, flg_m[4], loop_lock, loop_track, flg_m[1],
            self_clocked_mode});
         wr(A_CLR, seed[23:16], r);
         flg_m = flg_m & ~seed[23:16];
         ev(3'b000);
      end
      $display("interrupt test done");
      wr(6'h20, 8'hff, r);
      chk("bresp", {30'h0, CSIE_RESP_SLVERR}, {30'h0, r});
      rd(6'h24, d, r);
      chk("rdata", 32'h0, d);
      chk("rresp", {30'h0, CSIE_RESP_SLVERR}, {30'h0, r});
      $display("unmapped test done");
      summarize();
   end
endmodule
`default_nettype wire
